// ===== bench/fos_top_tb_top.sv
// Self-checking bench for the forced-stop control block.
// Assumes the trigger model and the register map of fos_cfg.svh.
`timescale 1ns/100ps
`include "fos_cfg.svh"
module fos_top_tb_top
    import fos_pkg::*;
;
    localparam logic [19:0] hole_addr = 20'hF0638;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [19:0] addr = 20'h00000;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0, rd = 1'b0, slow = 1'b0, seen;
    logic [15:0] rdata, v;
    logic [2:0] comparator, conv_trig = 3'h0;
    logic pin20, pin21, conv_trigger;
    logic [1:0] run = 2'h0, period = 2'h0, cmp_sel, stop1, stop2;
    logic [3:0] pwm_in = 4'h0, pwm_out, pwm_oe;
    logic [4:0] want = 5'h00;
    fos_pin_route_t pin_route;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;

    fos_trig_model fos_trig_model_inst (.mclk(mclk), .want(want),
        .slow(slow), .comparator(comparator), .pin20(pin20), .pin21(pin21));

    fos_top #(.FILTER_LEN(3)) fos_top_inst (.mclk(mclk), .reset(reset),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .comparator(comparator), .external_interrupt_pin_20(pin20),
        .external_interrupt_pin_21(pin21), .timer_count_run(run),
        .period_start(period), .timer_conv_trig(conv_trig),
        .conv_trigger(conv_trigger), .pin_route(pin_route),
        .comparator_interrupt_select(cmp_sel), .pwm_in(pwm_in),
        .pwm_out(pwm_out), .pwm_oe(pwm_oe), .stop1_active(stop1),
        .stop2_active(stop2));

    always #5 mclk = ~mclk;

    task automatic print_verdict;
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // A hang counts as a failure and still reaches the verdict
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            print_verdict;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    task automatic wr_reg(input logic [19:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [19:0] a, input logic [15:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_chk

    task automatic pulse_period;
        @(posedge mclk);
        period <= 2'b11;
        @(posedge mclk);
        period <= 2'b00;
    endtask : pulse_period

    // {oe, out} of one pair: stop1 wins, then stop2, else pass-through
    function automatic logic [3:0] exp_pair(input logic s1, input logic s2,
        input logic [1:0] code, input logic [1:0] pwm);
        if (s1)
            return code[1] ? {2'b11, {2{code[0]}}} : 4'h0;
        if (s2)
            return {2'b11, {2{code[0]}}};
        return {2'b11, pwm};
    endfunction : exp_pair

    initial
    begin
        void'($urandom(1516));
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        rd_chk(`FOS_ADDR_PFSEL, 16'h0000);
        rd_chk(`FOS_ADDR_CTRL0, 16'h0000);
        rd_chk(`FOS_ADDR_CTRL1, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            v = 16'($urandom) & `FOS_CTRL_WMASK;
            wr_reg(i[0] ? `FOS_ADDR_CTRL1 : `FOS_ADDR_CTRL0, v);
            wr_reg(hole_addr, ~v);
            rd_chk(i[0] ? `FOS_ADDR_CTRL1 : `FOS_ADDR_CTRL0, v);
            rd_chk(hole_addr, 16'h0000);
            wr_reg(`FOS_ADDR_PFSEL, {v[15:8], 1'b0, v[6:0]});
            rd_chk(`FOS_ADDR_PFSEL, {9'h000, v[6:0]});
            chk(cmp_sel, v[6:5]);
            rd_chk(`FOS_ADDR_RELEASE, 16'h0000);
        end
        wr_reg(`FOS_ADDR_CTRL0, 16'h0000);
        wr_reg(`FOS_ADDR_CTRL1, 16'h0000);
        want <= 5'b11000;
        slow <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            wr_reg(`FOS_ADDR_PFSEL, 16'h0010 | 16'(s));
            cyc(4);
            chk(pin_route, {~s[0], s[0], ~s[1], s[1]});
        end
        want <= 5'b00000;
        slow <= 1'b0;
        for (int b = 0; b < 2; b++)
        begin
            wr_reg(`FOS_ADDR_PFSEL, {11'h000, b[0], 4'h0});
            cyc(4);
            seen = 1'b0;
            want <= 5'b01000;
            @(posedge mclk);
            want <= 5'b00000;
            repeat (6)
            begin
                @(posedge mclk);
                #1 seen = seen | pin_route.pin20_irq;
            end
            chk(seen, b[0]);
            want <= 5'b01000;
            cyc(8);
            chk(pin_route.pin20_irq, 1'b1);
            want <= 5'b00000;
            cyc(8);
        end
        for (int k = 0; k < 3; k++)
        begin
            wr_reg(`FOS_ADDR_PFSEL, 16'(k << 2));
            cyc(2);
            for (int j = 0; j < 3; j++)
            begin
                @(posedge mclk);
                conv_trig <= 3'(1 << j);
                @(posedge mclk);
                conv_trig <= 3'h0;
                #1 chk(conv_trigger, k == j);
            end
        end
        wr_reg(`FOS_ADDR_PFSEL, 16'h0000);
        for (int c = 0; c < 4; c++)
        begin
            run <= 2'b00;
            pwm_in <= 4'($urandom);
            wr_reg(`FOS_ADDR_CTRL0, 16'h0010 | 16'(c * 5));
            run <= 2'b11;
            want <= 5'b00110;
            cyc(4);
            chk({stop1, pwm_oe[1:0], pwm_out[1:0]},
                {2'b00, exp_pair(0, 0, 0, pwm_in[1:0])});
            want <= 5'b00111;
            cyc(4);
            chk({stop1[0], pwm_oe[1:0], pwm_out[1:0]},
                {1'b1, exp_pair(1, 0, 2'(c), pwm_in[1:0])});
            wr_reg(`FOS_ADDR_RELEASE, 16'h0001);
            cyc(1);
            chk(stop1[0], c != 0);
            want <= 5'b00000;
            cyc(4);
            wr_reg(`FOS_ADDR_RELEASE, 16'h0001);
            cyc(1);
            chk(stop1[0], c[1]);
            run <= 2'b00;
            pulse_period;
            cyc(2);
            chk(stop1[0], c[1]);
            run <= 2'b11;
            pulse_period;
            cyc(2);
            chk(stop1[0], 1'b0);
        end
        for (int m = 0; m < 2; m++)
        begin
            run <= 2'b00;
            wr_reg(`FOS_ADDR_CTRL0, 16'h2001 | 16'(m << 8));
            run <= 2'b11;
            slow <= m[0];
            want <= 5'b00101;
            cyc(5);
            chk(stop2[0], 1'b0);
            want <= 5'b00111;
            cyc(5);
            chk({stop2[0], pwm_oe[1:0], pwm_out[1:0]},
                {1'b1, exp_pair(0, 1, 1, pwm_in[1:0])});
            pulse_period;
            cyc(2);
            chk(stop2[0], m[0]);
            want <= 5'b00000;
            cyc(5);
            pulse_period;
            cyc(2);
            chk(stop2[0], 1'b0);
        end
        wr_reg(`FOS_ADDR_PFSEL, 16'h0011);
        run <= 2'b00;
        wr_reg(`FOS_ADDR_CTRL0, 16'h8000);
        wr_reg(`FOS_ADDR_CTRL1, 16'h8003);
        run <= 2'b11;
        want <= 5'b01000;
        cyc(5);
        chk({stop2, pwm_oe, pwm_out, pin_route}, 14'h3FC4);
        rd_chk(`FOS_ADDR_STATUS, 16'h000C);
        want <= 5'b00000;
        pulse_period;
        cyc(2);
        chk(stop2, 2'b00);
        print_verdict;
    end
endmodule : fos_top_tb_top

// ===== bench/fos_trig_model.sv
// Model of the trigger sources: comparators and interrupt pins 20 and 21.
// Assumes the bench asks for levels on want; slow adds one cycle of delay.
`timescale 1ns/100ps
module fos_trig_model
    import fos_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Requested levels {pin 21, pin 20, comparators 2..0}
    input wire logic [4:0] want,
    input wire logic slow,
    // Source levels
    output logic [2:0] comparator,
    output logic pin20,
    output logic pin21
);
    logic [4:0] stage1 = 5'h00;
    logic [4:0] stage2 = 5'h00;

    // Both latencies keep the pulse width, so glitch tests stay exact
    always @(posedge mclk)
    begin
        stage1 <= want;
        stage2 <= stage1;
    end
    assign {pin21, pin20, comparator} = slow ? stage2 : stage1;
endmodule : fos_trig_model

// ===== core/fos_cfg.svh
// Constants for the timer output forced-stop control block.
// Assumes a 20-bit peripheral address space and 16-bit register data.
`ifndef FOS_CFG_SVH
`define FOS_CFG_SVH

// Register addresses
`define FOS_ADDR_PFSEL 20'hF05C6
`define FOS_ADDR_CTRL0 20'hF0630
`define FOS_ADDR_CTRL1 20'hF0632
`define FOS_ADDR_RELEASE 20'hF0634
`define FOS_ADDR_STATUS 20'hF0636

// Reset values and writable-bit masks
`define FOS_PFSEL_RESET 8'h00
`define FOS_CTRL_RESET 16'h0000
`define FOS_PFSEL_WMASK 8'h7F
`define FOS_CTRL_WMASK 16'hF17F

// Conversion trigger select codes
`define FOS_CONV_SEL_T0 2'h0
`define FOS_CONV_SEL_T1 2'h1
`define FOS_CONV_SEL_T2 2'h2

// First stop function clear conditions
`define FOS_CLR_WRITE 2'h0
`define FOS_CLR_WRITE_IDLE 2'h1
`define FOS_CLR_PERIOD 2'h2
`define FOS_CLR_PERIOD_IDLE 2'h3

// Output state codes while stopped
`define FOS_OUT_HIZ_LOW 2'h0
`define FOS_OUT_HIZ_HIGH 2'h1
`define FOS_OUT_LOW_LOW 2'h2
`define FOS_OUT_HIGH_HIGH 2'h3

// Noise filter sample count
`define FOS_FILTER_LEN 3

`endif

// ===== core/fos_noise_filter.sv
// Noise filter for external interrupt pin 20 with a bypass select.
// Assumes the pin is already synchronous to mclk.
`timescale 1ns/100ps
`include "fos_cfg.svh"
module fos_noise_filter
    import fos_pkg::*;
#(
    parameter int LEN = `FOS_FILTER_LEN
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Pin and control
    input wire logic pin,
    input wire logic bypass,
    output logic level
);
    logic [LEN-1:0] samples;
    logic [LEN-1:0] next_samples;
    logic next_level;

    // Unless bypassed, level only moves once every sample agrees
    always_comb
    begin
        next_samples = {samples[LEN-2:0], pin};
        next_level = level;
        if (bypass)
            next_level = pin;
        else if (&samples)
            next_level = 1'b1;
        else if (~|samples)
            next_level = 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            samples <= '0;
            level <= 1'b0;
        end
        else
        begin
            samples <= next_samples;
            level <= next_level;
        end
    end
endmodule : fos_noise_filter

// ===== core/fos_pkg.sv
// Types shared by the forced-stop control block.
// Assumes fos_cfg.svh supplies all numeric constants.
package fos_pkg;

    typedef struct packed {
        logic reserved7;
        logic comparator2_interrupt_select;
        logic comparator0_interrupt_select;
        logic pin20_filter_bypass;
        logic [1:0] conv_trigger_select;
        logic pin21_function_select;
        logic pin20_function_select;
    } fos_pfsel_t;

    typedef struct packed {
        logic stop2_pin20_enable;
        logic stop2_comparator2_enable;
        logic stop2_comparator1_enable;
        logic stop2_comparator0_enable;
        logic [2:0] reserved_hi;
        logic stop2_mode;
        logic reserved_lo;
        logic stop1_comparator2_enable;
        logic stop1_comparator1_enable;
        logic stop1_comparator0_enable;
        logic [1:0] stop1_clear_cond;
        logic [1:0] stop_output_state;
    } fos_ctrl_t;

    typedef struct packed {
        logic pin20_irq;
        logic pin20_restart;
        logic pin21_irq;
        logic pin21_restart;
    } fos_pin_route_t;

endpackage : fos_pkg

// ===== core/fos_stop_output.sv
// Drives one output pair, overriding the PWM levels while stopped.
// Assumes the pad resolves high impedance from the enable.
`timescale 1ns/100ps
`include "fos_cfg.svh"
module fos_stop_output
    import fos_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Stop state
    input wire logic stop1,
    input wire logic stop2,
    input wire logic [1:0] state,
    // Pin data
    input wire logic [1:0] pwm,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe
);
    logic [1:0] next_out;
    logic [1:0] next_oe;

    // First function overrides the second
    always_comb
    begin
        next_out = pwm;
        next_oe = 2'h3;
        if (stop1)
        begin
            case (state)
                `FOS_OUT_HIZ_LOW, `FOS_OUT_HIZ_HIGH:
                begin
                    next_out = 2'h0;
                    next_oe = 2'h0;
                end
                `FOS_OUT_LOW_LOW: next_out = 2'h0;
                `FOS_OUT_HIGH_HIGH: next_out = 2'h3;
                default: next_out = 2'h0;
            endcase
        end
        else if (stop2)
            next_out = state[0] ? 2'h3 : 2'h0;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pin_out <= 2'h0;
            pin_oe <= 2'h0;
        end
        else
        begin
            pin_out <= next_out;
            pin_oe <= next_oe;
        end
    end
endmodule : fos_stop_output

// ===== core/fos_top.sv
// Forced output stop control for two PWM output pairs plus the
// peripheral switch register. Assumes all inputs are synchronous to mclk,
// triggers are active high, and period_start pulses once per period.
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`include "fos_cfg.svh"

module fos_top
    import fos_pkg::*;
#(
    parameter int FILTER_LEN = `FOS_FILTER_LEN
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register port
    input wire logic [19:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Trigger sources
    input wire logic [2:0] comparator,
    input wire logic external_interrupt_pin_20,
    input wire logic external_interrupt_pin_21,
    // Timer status per pair
    input wire logic [1:0] timer_count_run,
    input wire logic [1:0] period_start,
    // Conversion trigger
    input wire logic [2:0] timer_conv_trig,
    output logic conv_trigger,
    // Pin routing
    output fos_pin_route_t pin_route,
    output logic [1:0] comparator_interrupt_select,
    // Output pairs, two pins each
    input wire logic [3:0] pwm_in,
    output logic [3:0] pwm_out,
    output logic [3:0] pwm_oe,
    // Stop state
    output logic [1:0] stop1_active,
    output logic [1:0] stop2_active
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    fos_pfsel_t pfsel;
    fos_pfsel_t next_pfsel;
    fos_ctrl_t [1:0] ctrl;
    fos_ctrl_t [1:0] next_ctrl;
    logic [15:0] next_rdata;
    logic [1:0] release_req;
    logic pin20_level;
    logic pin20_stop_src;
    logic next_conv_trigger;
    fos_pin_route_t next_pin_route;

    // Register decode. Release writes produce a pulse and store nothing.
    always_comb
    begin
        next_pfsel = pfsel;
        next_ctrl = ctrl;
        next_rdata = 16'h0000;
        release_req = 2'h0;
        if (wr)
        begin
            case (addr)
                `FOS_ADDR_PFSEL:
                    next_pfsel = fos_pfsel_t'(wdata[7:0] & `FOS_PFSEL_WMASK);
                `FOS_ADDR_CTRL0:
                    next_ctrl[0] = fos_ctrl_t'(wdata & `FOS_CTRL_WMASK);
                `FOS_ADDR_CTRL1:
                    next_ctrl[1] = fos_ctrl_t'(wdata & `FOS_CTRL_WMASK);
                `FOS_ADDR_RELEASE:
                    release_req = wdata[1:0];
                default:
                    release_req = 2'h0;
            endcase
        end
        if (rd)
        begin
            case (addr)
                `FOS_ADDR_PFSEL: next_rdata = {8'h00, pfsel};
                `FOS_ADDR_CTRL0: next_rdata = ctrl[0];
                `FOS_ADDR_CTRL1: next_rdata = ctrl[1];
                `FOS_ADDR_STATUS:
                    next_rdata = {12'h000, stop2_active, stop1_active};
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pfsel <= fos_pfsel_t'(`FOS_PFSEL_RESET);
            ctrl[0] <= fos_ctrl_t'(`FOS_CTRL_RESET);
            ctrl[1] <= fos_ctrl_t'(`FOS_CTRL_RESET);
            rdata <= 16'h0000;
        end
        else
        begin
            pfsel <= next_pfsel;
            ctrl <= next_ctrl;
            rdata <= next_rdata;
        end
    end

    fos_noise_filter #(
        .LEN(FILTER_LEN)
    ) u_filter (
        .mclk(mclk),
        .reset(reset),
        .pin(external_interrupt_pin_20),
        .bypass(pfsel.pin20_filter_bypass),
        .level(pin20_level)
    );

    // Pin 20 feeds the second stop only in its restart role
    assign pin20_stop_src = pin20_level & pfsel.pin20_function_select;

    // Pin routing and conversion trigger select
    always_comb
    begin
        next_pin_route.pin20_irq = pin20_level & ~pfsel.pin20_function_select;
        next_pin_route.pin20_restart = pin20_stop_src;
        next_pin_route.pin21_irq = external_interrupt_pin_21
            & ~pfsel.pin21_function_select;
        next_pin_route.pin21_restart = external_interrupt_pin_21
            & pfsel.pin21_function_select;
        case (pfsel.conv_trigger_select)
            `FOS_CONV_SEL_T0: next_conv_trigger = timer_conv_trig[0];
            `FOS_CONV_SEL_T1: next_conv_trigger = timer_conv_trig[1];
            `FOS_CONV_SEL_T2: next_conv_trigger = timer_conv_trig[2];
            default: next_conv_trigger = 1'b0;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pin_route <= '0;
            conv_trigger <= 1'b0;
        end
        else
        begin
            pin_route <= next_pin_route;
            conv_trigger <= next_conv_trigger;
        end
    end

    assign comparator_interrupt_select = {
        pfsel.comparator2_interrupt_select,
        pfsel.comparator0_interrupt_select
    };

    // Per-pair stop engines
    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_pair
            logic trig1;
            logic trig2;
            logic trig1_d;
            logic trig2_d;
            logic rise1;
            logic rise2;
            logic fall2;
            logic period;
            logic stop1;
            logic stop2;
            logic pend;
            logic fall_seen;
            logic next_stop1;
            logic next_stop2;
            logic next_pend;
            logic next_fall_seen;

            assign trig1 = |({ctrl[i].stop1_comparator2_enable,
                              ctrl[i].stop1_comparator1_enable,
                              ctrl[i].stop1_comparator0_enable}
                             & comparator);
            assign trig2 = |({ctrl[i].stop2_pin20_enable,
                              ctrl[i].stop2_comparator2_enable,
                              ctrl[i].stop2_comparator1_enable,
                              ctrl[i].stop2_comparator0_enable}
                             & {pin20_stop_src, comparator});
            assign rise1 = trig1 & ~trig1_d;
            assign rise2 = trig2 & ~trig2_d;
            assign fall2 = ~trig2 & trig2_d;
            // Period edges of a halted timer never release a stop
            assign period = period_start[i] & timer_count_run[i];

            always_comb
            begin
                next_stop1 = stop1;
                next_stop2 = stop2;
                next_pend = pend & stop1;
                next_fall_seen = fall_seen & stop2;
                case (ctrl[i].stop1_clear_cond)
                    `FOS_CLR_WRITE:
                        if (release_req[i])
                            next_stop1 = 1'b0;
                    `FOS_CLR_WRITE_IDLE:
                        if (release_req[i] && !trig1)
                            next_stop1 = 1'b0;
                    `FOS_CLR_PERIOD:
                    begin
                        if (release_req[i] && stop1)
                            next_pend = 1'b1;
                        if (pend && period)
                        begin
                            next_stop1 = 1'b0;
                            next_pend = 1'b0;
                        end
                    end
                    `FOS_CLR_PERIOD_IDLE:
                    begin
                        if (release_req[i] && stop1 && !trig1)
                            next_pend = 1'b1;
                        if (pend && period)
                        begin
                            next_stop1 = 1'b0;
                            next_pend = 1'b0;
                        end
                    end
                    default:
                        next_stop1 = stop1;
                endcase
                if (!ctrl[i].stop2_mode)
                begin
                    if (stop2 && period)
                        next_stop2 = 1'b0;
                end
                else
                begin
                    if (stop2 && fall2)
                        next_fall_seen = 1'b1;
                    if (stop2 && fall_seen && period)
                    begin
                        next_stop2 = 1'b0;
                        next_fall_seen = 1'b0;
                    end
                end
                // A new trigger edge wins over any clear in the same cycle
                if (rise1)
                begin
                    next_stop1 = 1'b1;
                    next_pend = 1'b0;
                end
                if (rise2)
                begin
                    next_stop2 = 1'b1;
                    next_fall_seen = 1'b0;
                end
            end

            always_ff @(posedge mclk)
            begin
                if (reset)
                begin
                    trig1_d <= 1'b0;
                    trig2_d <= 1'b0;
                    stop1 <= 1'b0;
                    stop2 <= 1'b0;
                    pend <= 1'b0;
                    fall_seen <= 1'b0;
                end
                else
                begin
                    trig1_d <= trig1;
                    trig2_d <= trig2;
                    stop1 <= next_stop1;
                    stop2 <= next_stop2;
                    pend <= next_pend;
                    fall_seen <= next_fall_seen;
                end
            end

            assign stop1_active[i] = stop1;
            assign stop2_active[i] = stop2;

            fos_stop_output u_out (
                .mclk(mclk),
                .reset(reset),
                .stop1(stop1),
                .stop2(stop2),
                .state(ctrl[i].stop_output_state),
                .pwm(pwm_in[2*i+:2]),
                .pin_out(pwm_out[2*i+:2]),
                .pin_oe(pwm_oe[2*i+:2])
            );

            sequence s_quiet_release;
                release_req[i] && !rise1;
            endsequence

            chk_stop1_immediate: assert property (
                stop1 && ctrl[i].stop1_clear_cond == `FOS_CLR_WRITE
                ##0 s_quiet_release |=> !stop1)
                else $error("First stop not cleared by release");
            chk_stop1_refused: assert property (
                stop1 && trig1
                && ctrl[i].stop1_clear_cond == `FOS_CLR_WRITE_IDLE
                ##0 s_quiet_release |=> stop1)
                else $error("Release during active trigger cleared stop");
            chk_stop1_deferred: assert property (
                stop1 && !period
                && ctrl[i].stop1_clear_cond == `FOS_CLR_PERIOD
                ##0 s_quiet_release |=> stop1)
                else $error("Deferred release cleared stop early");
            chk_stop2_auto: assert property (
                stop2 && !ctrl[i].stop2_mode && period && !rise2
                |=> !stop2)
                else $error("Second stop not cleared at period");
            chk_stop2_hold: assert property (
                stop2 && ctrl[i].stop2_mode && !fall_seen
                && !$rose(trig2) |=> stop2)
                else $error("Second stop released before reverse edge");
            chk_timer_halt: assert property (
                stop2 && !timer_count_run[i] |=> stop2)
                else $error("Stop released while timer halted");
            chk_output_hiz: assert property (
                stop1 && !ctrl[i].stop_output_state[1]
                && $stable(ctrl[i]) |=> pwm_oe[2*i+:2] == 2'h0)
                else $error("Outputs not released to high impedance");
        end
    endgenerate

    chk_conv_select: assert property (
        pfsel.conv_trigger_select == `FOS_CONV_SEL_T1
        && $stable(pfsel) |=> conv_trigger == $past(timer_conv_trig[1]))
        else $error("Conversion trigger not from timer unit 1");
    chk_pin21_route: assert property (
        pfsel.pin21_function_select |=> !pin_route.pin21_irq)
        else $error("Pin 21 interrupt active in restart role");
    chk_pin20_route: assert property (
        !pfsel.pin20_function_select |=> !pin_route.pin20_restart)
        else $error("Pin 20 restart active in interrupt role");
    chk_release_zero: assert property (
        rd && addr == `FOS_ADDR_RELEASE |=> rdata == 16'h0000)
        else $error("Release strobe read back nonzero");
endmodule : fos_top
